// *** pkg/bidio_consts.vh ***
`ifndef BIDIO_CONSTS_VH
`define BIDIO_CONSTS_VH

// Register indices; byte address is four times the index
`define BIDIO_IDX_P1_DATA 3'h0
`define BIDIO_IDX_P1_DIR 3'h1
`define BIDIO_IDX_P1_OPT 3'h2
`define BIDIO_IDX_P2_DATA 3'h3
`define BIDIO_IDX_P2_DIR 3'h4
`define BIDIO_IDX_P2_OPT 3'h5
`define BIDIO_IDX_IRQ_CTRL 3'h6
`define BIDIO_IDX_IRQ_STAT 3'h7

// Address field positions
`define BIDIO_ADDR_W 8
`define BIDIO_IDX_MSB 4
`define BIDIO_IDX_LSB 2

// Port widths
`define BIDIO_P1_W 8
`define BIDIO_P2_W 7
`define BIDIO_PIN_W 15
`define BIDIO_VEC_W 2

// Reset values
`define BIDIO_P1_DATA_RST 8'hff
`define BIDIO_P1_DIR_RST 8'h00
`define BIDIO_P1_OPT_RST 8'h40
`define BIDIO_P2_DATA_RST 7'h7f
`define BIDIO_P2_DIR_RST 7'h00
`define BIDIO_P2_OPT_RST 7'h00
`define BIDIO_IRQ_MASK_RST 1'h1

// Interrupt control fields
`define BIDIO_IRQ_MASK_BIT 0
`define BIDIO_IRQ_VEC_P1 0
`define BIDIO_IRQ_VEC_P2 1

`endif

// *** hdl/bidio_pin.v ***
`timescale 1ns/1ps
module bidio_pin (
  input wire dir,
  input wire latch,
  input wire opt,
  input wire alt_out_en,
  input wire alt_out,
  input wire pin_level,
  output reg drive_level,
  output reg drive_oe_n,
  output reg pullup_en,
  output reg read_bit,
  output reg alt_in,
  output reg irq_en
);

  always @* begin
    drive_level = 1'b0;
    drive_oe_n = 1'b1;
    pullup_en = 1'b0;
    read_bit = pin_level;
    alt_in = pin_level;
    irq_en = 1'b0;
    if (alt_out_en) begin
      drive_level = alt_out; // RULE5
      drive_oe_n = 1'b0; // RULE5
      if (!dir) begin
        read_bit = alt_out; // RULE6
      end else begin
        read_bit = latch;
      end
    end else begin
      case ({dir, opt}) // RULE4
        2'b00: begin
          alt_in = pin_level; // RULE8
          read_bit = pin_level; // RULE18
        end
        2'b01: begin
          pullup_en = 1'b1; // RULE19
          irq_en = 1'b1; // RULE19
          read_bit = pin_level; // RULE18
        end
        2'b10: begin
          drive_level = 1'b0;
          drive_oe_n = latch; // RULE3
          read_bit = latch; // RULE2
          alt_in = latch; // RULE7
        end
        2'b11: begin
          drive_level = latch; // RULE1
          drive_oe_n = 1'b0; // RULE3
          read_bit = latch; // RULE2
          alt_in = latch; // RULE7
        end
        default: begin
          drive_oe_n = 1'b1;
        end
      endcase
    end
  end

endmodule // bidio_pin

// *** hdl/bidio_port.v ***
// Added by the designer: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`include "bidio_consts.vh"

// Contract
// RULE1: Direction bit one makes the pin an output driven from its data latch.
// RULE2: In output mode a data read returns the latch, not the pin.
// RULE3: Option selects push-pull or open-drain; open-drain releases on latch one.
// RULE4: Direction and option decode to floating, pull-up, open-drain, push-pull.
// RULE5: Enabled peripheral output forces the pin to output, driving the peripheral signal.
// RULE6: Input pin with peripheral output enabled reads back the peripheral level.
// RULE7: Output pin feeds its latch level to the peripheral input.
// RULE8: Floating input passes its pin level to the peripheral input.
// RULE9: Software disables pin interrupt before using it as peripheral input.
// RULE10: Software avoids pull-up inputs for peripheral inputs to save current.
// RULE11: Bidirectional peripheral signals need the pin set as floating input.
// RULE12: Software keeps analog and digital functions apart; clock pins only clock.
// RULE13: Analog converter inputs need floating input configuration.
// RULE14: Software changes configurations only along safe transitions.
// RULE15: Interrupt request only when pin selects interrupt input and mask is clear.
// RULE16: Low-power modes keep pin states; pending external interrupt wakes device.
// RULE17: Bit x of direction, data and option registers controls pin x.
// RULE18: Direction bit zero makes an input whose data read returns the pin.
// RULE19: Option bit in input mode enables pull-up and interrupt source.
// RULE20: Request latch clears when the processor fetches its vector.
module bidio_port (
  input wire clk,
  input wire nrst,
  input wire [7:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [7:0] port_one_pins_in,
  output reg [7:0] port_one_pins_out,
  output reg [7:0] port_one_pins_oe_n,
  output reg [7:0] port_one_pullup_en,
  input wire [7:0] port_one_alt_out_en,
  input wire [7:0] port_one_alt_out,
  output reg [7:0] port_one_alt_in,
  input wire [6:0] port_two_pins_in,
  output reg [6:0] port_two_pins_out,
  output reg [6:0] port_two_pins_oe_n,
  output reg [6:0] port_two_pullup_en,
  input wire [6:0] port_two_alt_out_en,
  input wire [6:0] port_two_alt_out,
  output reg [6:0] port_two_alt_in,
  input wire [1:0] vector_fetch,
  output reg [1:0] ext_irq_req,
  output reg wake_req
);

  reg [7:0] p1_data;
  reg [7:0] p1_dir;
  reg [7:0] p1_opt;
  reg [6:0] p2_data;
  reg [6:0] p2_dir;
  reg [6:0] p2_opt;
  reg irq_mask;
  reg [1:0] irq_pend;
  reg [14:0] sync_1;
  reg [14:0] sync_2;
  reg [1:0] comb_prev;

  wire [14:0] all_dir;
  wire [14:0] all_data;
  wire [14:0] all_opt;
  wire [14:0] all_alt_en;
  wire [14:0] all_alt_out;
  wire [14:0] all_pins_in;
  wire [14:0] drv_level;
  wire [14:0] drv_oe_n;
  wire [14:0] pull_en;
  wire [14:0] rd_bits;
  wire [14:0] alt_in_bits;
  wire [14:0] irq_en;
  wire [2:0] reg_idx;
  wire setup_ph;
  wire access_ph;
  wire wr_en;
  wire addr_ok;
  wire [1:0] comb_level;
  wire [1:0] irq_event;
  reg [31:0] next_prdata;
  reg next_pslverr;
  reg [1:0] next_irq_pend;

  // Pack both ports so that bit x of each register reaches pin x
  assign all_dir = {p2_dir, p1_dir}; // RULE17
  assign all_data = {p2_data, p1_data}; // RULE17
  assign all_opt = {p2_opt, p1_opt}; // RULE17
  assign all_alt_en = {port_two_alt_out_en, port_one_alt_out_en};
  assign all_alt_out = {port_two_alt_out, port_one_alt_out};
  assign all_pins_in = {port_two_pins_in, port_one_pins_in};

  // Pins arrive from outside the clock domain
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      // Idle high, so a pull-up interrupt pin sees no false edge after reset
      sync_1 <= 15'h7fff;
      sync_2 <= 15'h7fff;
    end else begin
      sync_1 <= all_pins_in;
      sync_2 <= sync_1;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < `BIDIO_PIN_W; gi = gi + 1) begin : g_pin
      bidio_pin u_pin (
        .dir(all_dir[gi]),
        .latch(all_data[gi]),
        .opt(all_opt[gi]),
        .alt_out_en(all_alt_en[gi]),
        .alt_out(all_alt_out[gi]),
        .pin_level(sync_2[gi]),
        .drive_level(drv_level[gi]),
        .drive_oe_n(drv_oe_n[gi]),
        .pullup_en(pull_en[gi]),
        .read_bit(rd_bits[gi]),
        .alt_in(alt_in_bits[gi]),
        .irq_en(irq_en[gi])
      );
    end
  endgenerate

  // Pad and peripheral outputs registered; no low-power gating touches them
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      port_one_pins_out <= 8'h00;
      port_one_pins_oe_n <= 8'hff;
      port_one_pullup_en <= 8'h00;
      port_one_alt_in <= 8'h00;
      port_two_pins_out <= 7'h00;
      port_two_pins_oe_n <= 7'h7f;
      port_two_pullup_en <= 7'h00;
      port_two_alt_in <= 7'h00;
    end else begin
      port_one_pins_out <= drv_level[7:0]; // RULE16
      port_one_pins_oe_n <= drv_oe_n[7:0];
      port_one_pullup_en <= pull_en[7:0];
      port_one_alt_in <= alt_in_bits[7:0];
      port_two_pins_out <= drv_level[14:8]; // RULE16
      port_two_pins_oe_n <= drv_oe_n[14:8];
      port_two_pullup_en <= pull_en[14:8];
      port_two_alt_in <= alt_in_bits[14:8];
    end
  end

  // APB decode
  assign reg_idx = paddr[`BIDIO_IDX_MSB:`BIDIO_IDX_LSB];
  assign addr_ok = (paddr[7:5] == 3'h0) && (paddr[1:0] == 2'h0);
  assign setup_ph = psel && !penable;
  assign access_ph = psel && penable && pready;
  assign wr_en = access_ph && pwrite && addr_ok;

  always @* begin
    next_prdata = 32'h00000000;
    next_pslverr = !addr_ok;
    case (reg_idx)
      `BIDIO_IDX_P1_DATA: next_prdata = {24'h000000, rd_bits[7:0]}; // RULE2
      `BIDIO_IDX_P1_DIR: next_prdata = {24'h000000, p1_dir};
      `BIDIO_IDX_P1_OPT: next_prdata = {24'h000000, p1_opt};
      `BIDIO_IDX_P2_DATA: next_prdata = {25'h0000000, rd_bits[14:8]}; // RULE18
      `BIDIO_IDX_P2_DIR: next_prdata = {25'h0000000, p2_dir};
      `BIDIO_IDX_P2_OPT: next_prdata = {25'h0000000, p2_opt};
      `BIDIO_IDX_IRQ_CTRL: next_prdata = {31'h00000000, irq_mask};
      `BIDIO_IDX_IRQ_STAT: next_prdata = {30'h00000000, irq_pend};
      default: next_prdata = 32'h00000000;
    endcase
    if (!addr_ok) begin
      next_prdata = 32'h00000000;
    end
  end

  // Zero wait states: pready rises in the first access cycle
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (setup_ph) begin
      prdata <= pwrite ? 32'h00000000 : next_prdata;
      pready <= 1'b1;
      pslverr <= next_pslverr;
    end else begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // Writes to the latch in input mode only change the latch
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      p1_data <= `BIDIO_P1_DATA_RST;
      p1_dir <= `BIDIO_P1_DIR_RST;
      p1_opt <= `BIDIO_P1_OPT_RST;
      p2_data <= `BIDIO_P2_DATA_RST;
      p2_dir <= `BIDIO_P2_DIR_RST;
      p2_opt <= `BIDIO_P2_OPT_RST;
      irq_mask <= `BIDIO_IRQ_MASK_RST;
    end else if (wr_en) begin
      case (reg_idx)
        `BIDIO_IDX_P1_DATA: p1_data <= pwdata[7:0]; // RULE1
        `BIDIO_IDX_P1_DIR: p1_dir <= pwdata[7:0];
        `BIDIO_IDX_P1_OPT: p1_opt <= pwdata[7:0];
        `BIDIO_IDX_P2_DATA: p2_data <= pwdata[6:0]; // RULE1
        `BIDIO_IDX_P2_DIR: p2_dir <= pwdata[6:0];
        `BIDIO_IDX_P2_OPT: p2_opt <= pwdata[6:0];
        `BIDIO_IDX_IRQ_CTRL: irq_mask <= pwdata[`BIDIO_IRQ_MASK_BIT];
        default: irq_mask <= irq_mask;
      endcase
    end
  end

  // Pins on one vector combine: any enabled pin low pulls the line low
  assign comb_level[`BIDIO_IRQ_VEC_P1] = &(sync_2[7:0] | ~irq_en[7:0]); // RULE15
  assign comb_level[`BIDIO_IRQ_VEC_P2] = &(sync_2[14:8] | ~irq_en[14:8]); // RULE15
  assign irq_event = comb_prev & ~comb_level;

  always @* begin
    next_irq_pend = irq_pend & ~vector_fetch; // RULE20
    next_irq_pend = next_irq_pend | irq_event;
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      comb_prev <= 2'h3;
      irq_pend <= 2'h0;
      ext_irq_req <= 2'h0;
      wake_req <= 1'b0;
    end else begin
      comb_prev <= comb_level;
      irq_pend <= next_irq_pend;
      ext_irq_req <= irq_mask ? 2'h0 : next_irq_pend; // RULE15
      wake_req <= |next_irq_pend; // RULE16
    end
  end

endmodule // bidio_port

// *** test/bidio_assertions.sv ***
`timescale 1ns/1ps
module bidio_assertions (
  input wire clk,
  input wire nrst,
  input wire [7:0] paddr,
  input wire psel,
  input wire penable,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire [7:0] port_one_pins_out,
  input wire [7:0] port_one_pins_oe_n,
  input wire [7:0] port_one_alt_out_en,
  input wire [7:0] port_one_alt_out,
  input wire [6:0] port_two_pins_out,
  input wire [6:0] port_two_pins_oe_n,
  input wire [6:0] port_two_alt_out_en,
  input wire [6:0] port_two_alt_out,
  input wire [1:0] ext_irq_req,
  input wire wake_req
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  property p_alt1; port_one_alt_out_en != 8'h00 |=> (port_one_pins_oe_n & $past(port_one_alt_out_en)) == 8'h00
    && ((port_one_pins_out ^ $past(port_one_alt_out)) & $past(port_one_alt_out_en)) == 8'h00; endproperty
  a_alt1: assert property (p_alt1) else $error("peripheral drive missing on port one");
  property p_alt2; port_two_alt_out_en != 7'h00 |=> (port_two_pins_oe_n & $past(port_two_alt_out_en)) == 7'h00
    && ((port_two_pins_out ^ $past(port_two_alt_out)) & $past(port_two_alt_out_en)) == 7'h00; endproperty
  a_alt2: assert property (p_alt2) else $error("peripheral drive missing on port two");
  property p_rdy0; psel && !penable |=> pready; endproperty
  a_rdy0: assert property (p_rdy0) else $error("no ready in first access cycle");
  property p_rdy1; pready |=> !pready; endproperty
  a_rdy1: assert property (p_rdy1) else $error("ready longer than one cycle");
  property p_err; psel && !penable && (paddr[7:5] != 3'h0 || paddr[1:0] != 2'h0) |=> pslverr; endproperty
  a_err: assert property (p_err) else $error("unmapped address not refused");
  property p_erd; pslverr |-> pready && prdata == 32'h0; endproperty
  a_erd: assert property (p_erd) else $error("error without ready or with data");
  property p_idle; !pready |-> prdata == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("read data outside access");
  property p_wake; ext_irq_req != 2'h0 |-> wake_req; endproperty
  a_wake: assert property (p_wake) else $error("request without wake");
  c_err: cover property (pslverr);
  c_irq: cover property (ext_irq_req != 2'h0);
  c_alt: cover property (port_one_alt_out_en != 8'h00);
endmodule // bidio_assertions
bind bidio_port bidio_assertions u_chk (.clk, .nrst, .paddr, .psel, .penable, .prdata, .pready, .pslverr,
  .port_one_pins_out, .port_one_pins_oe_n, .port_one_alt_out_en, .port_one_alt_out, .port_two_pins_out,
  .port_two_pins_oe_n, .port_two_alt_out_en, .port_two_alt_out, .ext_irq_req, .wake_req);

// *** test/bidio_pin_model.sv ***
`timescale 1ns/1ps
module bidio_pin_model #(parameter int W = 8) (
  input wire clk,
  input wire [W-1:0] oe_n,
  input wire [W-1:0] drv,
  input wire [W-1:0] pull,
  input wire [W-1:0] ext_en,
  input wire [W-1:0] ext_val,
  output wire [W-1:0] pin
);
  logic [W-1:0] noise = '0;
  always @(posedge clk) noise <= ~noise;
  // Device drive wins, then the outside driver, then the pull-up; an open line wanders
  assign pin = (~oe_n & drv) | (oe_n & ext_en & ext_val) | (oe_n & ~ext_en & (pull | noise));
endmodule // bidio_pin_model

// *** test/tb_top.sv ***
`timescale 1ns/1ps
`include "bidio_consts.vh"
module tb_top;
  logic clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, e;
  logic [7:0] paddr = 8'h00, a1_en = 8'h00, a1_v = 8'h00, x1_en = 8'hff, x1_v = 8'h5a;
  logic [6:0] a2_en = 7'h00, a2_v = 7'h00, x2_en = 7'h7f, x2_v = 7'h2b;
  logic [1:0] vector_fetch = 2'h0;
  logic [31:0] pwdata = 32'h0, q;
  wire [31:0] prdata;
  wire pready, pslverr, wake_req;
  wire [7:0] p1_in, p1_out, p1_oe_n, p1_pu, p1_ai;
  wire [6:0] p2_in, p2_out, p2_oe_n, p2_pu, p2_ai;
  wire [1:0] ext_irq_req;
  int error_cnt = 0, total_checks = 0;
  always #2 clk = ~clk;
  bidio_port u_dut (.clk, .nrst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
    .port_one_pins_in(p1_in), .port_one_pins_out(p1_out), .port_one_pins_oe_n(p1_oe_n), .port_one_pullup_en(p1_pu),
    .port_one_alt_out_en(a1_en), .port_one_alt_out(a1_v), .port_one_alt_in(p1_ai), .port_two_pins_in(p2_in),
    .port_two_pins_out(p2_out), .port_two_pins_oe_n(p2_oe_n), .port_two_pullup_en(p2_pu),
    .port_two_alt_out_en(a2_en), .port_two_alt_out(a2_v), .port_two_alt_in(p2_ai), .vector_fetch,
    .ext_irq_req, .wake_req);
  bidio_pin_model #(.W(8)) u_p1 (.clk, .oe_n(p1_oe_n), .drv(p1_out), .pull(p1_pu), .ext_en(x1_en),
    .ext_val(x1_v), .pin(p1_in));
  bidio_pin_model #(.W(7)) u_p2 (.clk, .oe_n(p2_oe_n), .drv(p2_out), .pull(p2_pu), .ext_en(x2_en),
    .ext_val(x2_v), .pin(p2_in));
  task automatic test_done;
    if (error_cnt == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input [31:0] got, input [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input [7:0] a, input w, input [31:0] d);
    int n = 0;
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      error_cnt++;
      test_done;
    end
    @(posedge clk);
  endtask
  task automatic wr(input [2:0] i, input [31:0] d);
    apb({i, 2'h0}, 1'b1, d);
  endtask
  task automatic rd(input [2:0] i, input [31:0] exp);
    apb({i, 2'h0}, 1'b0, 32'h0);
    chk(q, exp);
  endtask
  task automatic t_reset;
    logic [7:0] rv [7] = '{8'h5a, 8'h00, 8'h40, 8'h2b, 8'h00, 8'h00, 8'h01};
    for (int i = 0; i < 7; i++) rd(i[2:0], {24'h0, rv[i]});
    chk(p1_oe_n, 8'hff);
    apb(8'h21, 1'b0, 32'h0);
    chk(e, 1'b1);
    chk(q, 32'h0);
    apb(8'h02, 1'b1, 32'h0);
    chk(e, 1'b1);
  endtask
  task automatic t_output;
    wr(`BIDIO_IDX_P1_DIR, 8'hff);
    wr(`BIDIO_IDX_P2_DIR, 7'h7f);
    rd(`BIDIO_IDX_P1_DATA, 8'hff);
    rd(`BIDIO_IDX_P2_DATA, 7'h7f);
    wr(`BIDIO_IDX_P1_DATA, 8'ha5);
    wr(`BIDIO_IDX_P1_OPT, 8'h0f);
    wr(`BIDIO_IDX_P1_DIR, 8'hff);
    wr(`BIDIO_IDX_P2_DATA, 7'h55);
    wr(`BIDIO_IDX_P2_OPT, 7'h7f);
    wr(`BIDIO_IDX_P2_DIR, 7'h7f);
    @(posedge clk);
    chk(p1_oe_n, 8'ha0);
    chk(p1_out & ~p1_oe_n, 8'h05);
    chk(p1_ai, 8'ha5);
    rd(`BIDIO_IDX_P1_DATA, 8'ha5);
    chk({p2_oe_n, p2_out}, 14'h0055);
    rd(`BIDIO_IDX_P2_DATA, 7'h55);
  endtask
  task automatic t_input;
    x1_en <= 8'hff;
    x1_v <= 8'h3c;
    wr(`BIDIO_IDX_P1_DIR, 8'h00);
    wr(`BIDIO_IDX_P1_OPT, 8'h00);
    repeat (4) @(posedge clk);
    rd(`BIDIO_IDX_P1_DATA, 8'h3c);
    chk({p1_ai, p1_pu, p1_oe_n}, 24'h3c00ff);
    wr(`BIDIO_IDX_P1_OPT, 8'hff);
    @(posedge clk);
    chk(p1_pu, 8'hff);
  endtask
  task automatic t_alt;
    wr(`BIDIO_IDX_P1_OPT, 8'h00);
    a1_en <= 8'h0f;
    a1_v <= 8'h05;
    a2_en <= 7'h01;
    a2_v <= 7'h00;
    repeat (2) @(posedge clk);
    chk(p1_oe_n, 8'hf0);
    rd(`BIDIO_IDX_P1_DATA, 8'h35);
    a1_en <= 8'h00;
    a2_en <= 7'h00;
  endtask
  task automatic t_irq;
    x1_en <= 8'hfe;
    wr(`BIDIO_IDX_P1_OPT, 8'h01);
    repeat (4) @(posedge clk);
    vector_fetch <= 2'h3;
    @(posedge clk);
    vector_fetch <= 2'h0;
    rd(`BIDIO_IDX_IRQ_STAT, 32'h0);
    x1_en <= 8'hff;
    repeat (6) @(posedge clk);
    chk(ext_irq_req, 2'h0);
    rd(`BIDIO_IDX_IRQ_STAT, 32'h1);
    wr(`BIDIO_IDX_IRQ_CTRL, 32'h0);
    @(posedge clk);
    chk({ext_irq_req, wake_req}, 3'h3);
    vector_fetch <= 2'h1;
    @(posedge clk);
    vector_fetch <= 2'h0;
    repeat (2) @(posedge clk);
    chk(ext_irq_req, 2'h0);
  endtask
  task automatic t_irq2;
    wr(`BIDIO_IDX_P2_OPT, 7'h00);
    wr(`BIDIO_IDX_P2_DIR, 7'h00);
    // Falling edge on a floating input must not request
    x2_v <= 7'h7e;
    repeat (4) @(posedge clk);
    rd(`BIDIO_IDX_P2_DATA, 7'h7e);
    chk(ext_irq_req, 2'h0);
    x2_v <= 7'h7f;
    repeat (3) @(posedge clk);
    wr(`BIDIO_IDX_P2_OPT, 7'h01);
    x2_v <= 7'h7e;
    repeat (6) @(posedge clk);
    chk({ext_irq_req, wake_req}, 3'h5);
    vector_fetch <= 2'h2;
    @(posedge clk);
    vector_fetch <= 2'h0;
    repeat (2) @(posedge clk);
    chk({ext_irq_req, wake_req}, 3'h0);
  endtask
  initial begin
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset;
    t_output;
    t_input;
    t_alt;
    t_irq;
    t_irq2;
    test_done;
  end
endmodule // tb_top
